//--- src/emission_timing_preamble_control.sv
// Timing manager with its record store, and the preamble parser below it.
// Assumes the demultiplexer shares clk; the time reference tick is a raw pin.
//
// Operation
// - Accept and store timing records.
// - Records control only, never emitted.
// - Reference time fixes bootstrap leading edge.
// - Same reference yields frequency reference.
// - Buffer records well ahead of use.
// - Match copies by emission time; majority vote.
// - Copy counts read from record stream.
// - Pass preamble copy count to parser.
// - Bootstrap config, antenna delay, path delays.
// - Preamble insertion, offsets, identifier insertion control.
// - Parser accepts and buffers preamble packets.
// - Release preamble right after the bootstrap.
// - Strip length and check fields.
// - Decode stage instructions, deliver when told.
// - Preamble held until its frame emits.
// - Match preamble copies by emission time.
`timescale 1ns/1ps
module emission_timing_preamble_control
  import etpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Timing records from the demultiplexer
  input wire logic tmValid,
  input wire logic [TIME_W-1:0] tmTime,
  input wire logic [3:0] tmCopies,
  input wire logic [3:0] tmPreCopies,
  input wire logic [15:0] tmOffset,
  input wire logic [15:0] tmAntDelay,
  input wire logic [15:0] tmNetDelay,
  input wire logic [7:0] tmBsConfig,
  input wire logic [3:0] tmTxIdLevel,
  input wire logic tmTxIdOn,
  // Precise time reference tick pin
  input wire logic refTickPin,
  // Preamble bytes from the demultiplexer
  input wire logic preValid,
  input wire logic preFirst,
  input wire logic preLast,
  input wire logic [7:0] preData,
  input wire logic [TIME_W-1:0] preTime,
  // Emission control
  output logic [TIME_W-1:0] timeNow,
  output logic freqRef,
  output logic bootstrapStart,
  output logic [7:0] bootstrapConfig,
  output logic [15:0] antennaPathDelayCompensation,
  output logic [15:0] dataPathDelay,
  output logic [3:0] txIdLevel,
  output logic txIdEnable,
  output logic recordDrop,
  // Preamble stream and stage instructions
  output logic insValid,
  output logic insLast,
  output logic [7:0] insData,
  output logic stageValid,
  output logic [7:0] stageModulation,
  output logic [7:0] stageCoding,
  output logic [3:0] preambleCopies
);

  // ==========================================================================
  // Time reference
  logic refMeta, refSync, refLast;
  logic tick;
  logic [TIME_W-1:0] next_timeNow, nowNext;

  assign tick = refSync & ~refLast;
  assign nowNext = timeNow + 32'h0000_0001;

  always_comb begin
    next_timeNow = timeNow;
    if (tick) begin
      next_timeNow = nowNext;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refLast <= 1'b0;
      timeNow <= TIME_RESET;
      freqRef <= 1'b0;
    end else begin
      refMeta <= refTickPin;
      refSync <= refMeta;
      refLast <= refSync;
      timeNow <= next_timeNow;
      freqRef <= tick;
    end
  end

  // ==========================================================================
  // Record store and emission scheduling
  logic slotValid [SLOTS];
  logic [TIME_W-1:0] slotTime [SLOTS];
  record_type slotRec [SLOTS];
  logic [3:0] slotVotes [SLOTS];
  logic [3:0] slotSeen [SLOTS];
  logic slotFired [SLOTS];
  logic next_slotValid [SLOTS];
  logic [TIME_W-1:0] next_slotTime [SLOTS];
  record_type next_slotRec [SLOTS];
  logic [3:0] next_slotVotes [SLOTS];
  logic [3:0] next_slotSeen [SLOTS];
  logic next_slotFired [SLOTS];

  logic next_bootstrapStart, next_txIdEnable, next_recordDrop;
  logic [7:0] next_bootstrapConfig;
  logic [15:0] next_antennaPathDelayCompensation, next_dataPathDelay;
  logic [3:0] next_txIdLevel, preCopies, next_preCopies;
  logic setupGo, releaseGo, discardGo;
  logic next_setupGo, next_releaseGo, next_discardGo;
  logic [TIME_W-1:0] setupTime, releaseTime, discardTime;
  logic [TIME_W-1:0] next_setupTime, next_releaseTime, next_discardTime;
  logic hit, free;
  logic [SLOT_W-1:0] hitIdx, freeIdx;
  logic [TIME_W-1:0] launch;
  record_type incoming;

  // Timing records steer the control outputs only; they never reach insData.
  assign incoming = {tmOffset, tmAntDelay, tmNetDelay, tmBsConfig,
                     tmTxIdLevel, tmTxIdOn, tmPreCopies};

  always_comb begin
    hit = 1'b0;
    free = 1'b0;
    hitIdx = '0;
    freeIdx = '0;
    launch = TIME_RESET;
    next_slotValid = slotValid;
    next_slotTime = slotTime;
    next_slotRec = slotRec;
    next_slotVotes = slotVotes;
    next_slotSeen = slotSeen;
    next_slotFired = slotFired;
    next_bootstrapStart = 1'b0;
    next_bootstrapConfig = bootstrapConfig;
    next_antennaPathDelayCompensation = antennaPathDelayCompensation;
    next_dataPathDelay = dataPathDelay;
    next_txIdLevel = txIdLevel;
    next_txIdEnable = txIdEnable;
    next_recordDrop = 1'b0;
    next_preCopies = preCopies;
    next_setupGo = 1'b0;
    next_setupTime = setupTime;
    next_releaseGo = 1'b0;
    next_releaseTime = releaseTime;
    next_discardGo = 1'b0;
    next_discardTime = discardTime;

    // When two slots act in one tick the higher index wins the strobes.
    for (int i = 0; i < SLOTS; i++) begin
      launch = launch_time(slotTime[i], slotRec[i]);
      if (slotValid[i] && tick) begin
        if (launch - SETUP_LEAD == nowNext) begin
          next_setupGo = 1'b1;
          next_setupTime = slotTime[i];
        end
        if (launch == nowNext) begin
          next_bootstrapStart = 1'b1;
          next_bootstrapConfig = slotRec[i][REC_CFG_LSB +: 8];
          next_antennaPathDelayCompensation = slotRec[i][REC_ANT_LSB +: 16];
          next_dataPathDelay = slotRec[i][REC_NET_LSB +: 16];
          next_txIdLevel = slotRec[i][REC_LVL_LSB +: 4];
          next_txIdEnable = slotRec[i][REC_TXON];
          next_releaseGo = 1'b1;
          next_releaseTime = slotTime[i];
          next_slotFired[i] = 1'b1;
        end else if (launch < nowNext) begin
          next_slotValid[i] = 1'b0;
          if (!slotFired[i]) begin
            next_discardGo = 1'b1;
            next_discardTime = slotTime[i];
          end
        end
      end
    end

    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slotValid[i] && slotTime[i] == tmTime) begin
        hit = 1'b1;
        hitIdx = SLOT_W'(i);
      end
      if (!slotValid[i]) begin
        free = 1'b1;
        freeIdx = SLOT_W'(i);
      end
    end

    if (tmValid) begin
      if (hit) begin
        // Extra copies beyond the announced count are ignored.
        if (slotSeen[hitIdx] < tmCopies) begin
          next_slotSeen[hitIdx] = slotSeen[hitIdx] + 4'h1;
          next_slotVotes[hitIdx] = vote_count(incoming == slotRec[hitIdx],
                                              slotVotes[hitIdx]);
          if (slotVotes[hitIdx] == 4'h0) begin
            next_slotRec[hitIdx] = incoming;
          end
        end
      end else if (free) begin
        next_slotValid[freeIdx] = 1'b1;
        next_slotTime[freeIdx] = tmTime;
        next_slotRec[freeIdx] = incoming;
        next_slotVotes[freeIdx] = 4'h1;
        next_slotSeen[freeIdx] = 4'h1;
        next_slotFired[freeIdx] = 1'b0;
      end else begin
        next_recordDrop = 1'b1;
      end
      next_preCopies = tmPreCopies;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < SLOTS; i++) begin
        slotValid[i] <= 1'b0;
        slotTime[i] <= TIME_RESET;
        slotRec[i] <= '0;
        slotVotes[i] <= 4'h0;
        slotSeen[i] <= 4'h0;
        slotFired[i] <= 1'b0;
      end
      bootstrapStart <= 1'b0;
      bootstrapConfig <= 8'h00;
      antennaPathDelayCompensation <= 16'h0000;
      dataPathDelay <= 16'h0000;
      txIdLevel <= 4'h0;
      txIdEnable <= 1'b0;
      recordDrop <= 1'b0;
      preCopies <= 4'h0;
      setupGo <= 1'b0;
      setupTime <= TIME_RESET;
      releaseGo <= 1'b0;
      releaseTime <= TIME_RESET;
      discardGo <= 1'b0;
      discardTime <= TIME_RESET;
    end else begin
      slotValid <= next_slotValid;
      slotTime <= next_slotTime;
      slotRec <= next_slotRec;
      slotVotes <= next_slotVotes;
      slotSeen <= next_slotSeen;
      slotFired <= next_slotFired;
      bootstrapStart <= next_bootstrapStart;
      bootstrapConfig <= next_bootstrapConfig;
      antennaPathDelayCompensation <= next_antennaPathDelayCompensation;
      dataPathDelay <= next_dataPathDelay;
      txIdLevel <= next_txIdLevel;
      txIdEnable <= next_txIdEnable;
      recordDrop <= next_recordDrop;
      preCopies <= next_preCopies;
      setupGo <= next_setupGo;
      setupTime <= next_setupTime;
      releaseGo <= next_releaseGo;
      releaseTime <= next_releaseTime;
      discardGo <= next_discardGo;
      discardTime <= next_discardTime;
    end
  end

  // ==========================================================================
  // Preamble parser
  preamble_parser preamble_parser_inst (
    .clk(clk),
    .srst(srst),
    .preValid(preValid),
    .preFirst(preFirst),
    .preLast(preLast),
    .preData(preData),
    .preTime(preTime),
    .copiesExpected(preCopies),
    .setupGo(setupGo),
    .setupTime(setupTime),
    .releaseGo(releaseGo),
    .releaseTime(releaseTime),
    .discardGo(discardGo),
    .discardTime(discardTime),
    .insValid(insValid),
    .insLast(insLast),
    .insData(insData),
    .stageValid(stageValid),
    .stageModulation(stageModulation),
    .stageCoding(stageCoding),
    .preambleCopies(preambleCopies)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_time_advance: assert property (tick |=> timeNow == $past(timeNow) + 32'h0000_0001)
    else $error("time did not advance on a reference tick");

  a_time_hold: assert property (!tick |=> $stable(timeNow))
    else $error("time moved without a reference tick");

  a_freq_ref: assert property ($rose(refSync) |=> freqRef ##1 !freqRef)
    else $error("frequency reference did not follow the tick");

  a_boot_on_tick: assert property (bootstrapStart |-> $past(tick) && !$past(bootstrapStart))
    else $error("bootstrap start not aligned to a tick");

  a_boot_release: assert property (bootstrapStart |-> releaseGo)
    else $error("bootstrap fired without a preamble release");

  a_pre_follows: assert property ($rose(insValid) |-> $past(releaseGo) && $past(bootstrapStart))
    else $error("preamble stream started without a bootstrap");

  a_drop_cause: assert property (recordDrop |-> $past(tmValid) && !$past(free) && !$past(hit))
    else $error("record dropped while a slot was available");

  a_unique_slot: assert property (slotValid[0] && slotValid[1] |-> slotTime[0] != slotTime[1])
    else $error("two slots hold the same emission time");

  a_setup_lead: assert property (setupGo |-> $past(tick) && !releaseGo)
    else $error("setup strobe misplaced");

  a_copies_pass: assert property (tmValid |=> preCopies == $past(tmPreCopies))
    else $error("preamble copy count not forwarded");

  c_bootstrap: cover property (bootstrapStart ##[1:40] insLast);
  c_drop: cover property (recordDrop);
  c_setup: cover property (stageValid);
  c_discard: cover property (discardGo);

endmodule : emission_timing_preamble_control

//--- pkg/etpc_pkg.sv
// Constants, types and helpers shared by the emission timing and preamble logic.
// Assumes one clock domain; the time reference arrives as a tick pin.
package etpc_pkg;

  // ==========================================================================
  // Sizes
  localparam int TIME_W = 32;
  localparam int SLOTS = 4;
  localparam int SLOT_W = 2;
  localparam int PRE_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] PTR_LAST = 5'h1f;
  localparam logic [PTR_W-1:0] CHK_BYTES = 5'h02;
  localparam logic [1:0] HDR_BYTES = 2'h2;

  // ==========================================================================
  // Timing counts, in reference ticks, and the vote ceiling
  localparam logic [TIME_W-1:0] SETUP_LEAD = 32'h0000_0010;
  localparam logic [TIME_W-1:0] TIME_RESET = 32'h0000_0000;
  localparam logic [3:0] VOTE_MAX = 4'hf;

  // ==========================================================================
  // Record field positions
  localparam int REC_PRE_LSB = 0;
  localparam int REC_TXON = 4;
  localparam int REC_LVL_LSB = 5;
  localparam int REC_CFG_LSB = 9;
  localparam int REC_NET_LSB = 17;
  localparam int REC_ANT_LSB = 33;
  localparam int REC_OFF_LSB = 49;
  localparam int REC_W = 65;

  typedef logic [REC_W-1:0] record_type;
  typedef enum logic [1:0] {P_EMPTY, P_FILL, P_HELD, P_SEND} parse_state_type;

  // ==========================================================================
  // Helpers
  // The offset is signed so that a transmitter may be advanced or delayed.
  function automatic logic [TIME_W-1:0] launch_time(input logic [TIME_W-1:0] t,
                                                   input record_type r);
    launch_time = t + {{16{r[REC_OFF_LSB+15]}}, r[REC_OFF_LSB +: 16]}
                - {16'h0000, r[REC_ANT_LSB +: 16]};
  endfunction : launch_time

  function automatic logic [3:0] vote_count(input logic same, input logic [3:0] cnt);
    if (cnt == 4'h0) begin
      vote_count = 4'h1;
    end else if (same) begin
      vote_count = (cnt == VOTE_MAX) ? cnt : cnt + 4'h1;
    end else begin
      vote_count = cnt - 4'h1;
    end
  endfunction : vote_count

endpackage : etpc_pkg

//--- src/preamble_parser.sv
// Preamble buffer, trimmer and stage instruction decoder.
// Assumes release, setup and discard strobes come from the timing manager.
`timescale 1ns/1ps
module preamble_parser
  import etpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Preamble bytes from the demultiplexer
  input wire logic preValid,
  input wire logic preFirst,
  input wire logic preLast,
  input wire logic [7:0] preData,
  input wire logic [TIME_W-1:0] preTime,
  // Control from the timing manager
  input wire logic [3:0] copiesExpected,
  input wire logic setupGo,
  input wire logic [TIME_W-1:0] setupTime,
  input wire logic releaseGo,
  input wire logic [TIME_W-1:0] releaseTime,
  input wire logic discardGo,
  input wire logic [TIME_W-1:0] discardTime,
  // Outputs
  output logic insValid,
  output logic insLast,
  output logic [7:0] insData,
  output logic stageValid,
  output logic [7:0] stageModulation,
  output logic [7:0] stageCoding,
  output logic [3:0] preambleCopies
);

  // ==========================================================================
  // State
  parse_state_type state, next_state;
  logic [7:0] mem [PRE_DEPTH];
  logic [7:0] next_mem [PRE_DEPTH];
  logic [TIME_W-1:0] bufTime, next_bufTime;
  logic [PTR_W-1:0] wr, next_wr, rd, next_rd;
  logic [1:0] hdr, next_hdr;
  logic [3:0] next_copies;
  logic next_insValid, next_insLast, next_stageValid;
  logic [7:0] next_insData, next_stageModulation, next_stageCoding;

  always_comb begin
    next_state = state;
    next_mem = mem;
    next_bufTime = bufTime;
    next_wr = wr;
    next_rd = rd;
    next_hdr = hdr;
    next_copies = preambleCopies;
    next_insValid = 1'b0;
    next_insLast = 1'b0;
    next_insData = insData;
    next_stageValid = 1'b0;
    next_stageModulation = stageModulation;
    next_stageCoding = stageCoding;
    unique case (state)
      P_EMPTY: begin
        if (preValid && preFirst && !preLast) begin
          next_bufTime = preTime;
          next_hdr = 2'h1;
          next_wr = '0;
          next_state = P_FILL;
        end
      end
      P_FILL: begin
        if (preValid) begin
          if (hdr != HDR_BYTES) begin
            next_hdr = hdr + 2'h1;
          end else if (wr != PTR_LAST) begin
            next_mem[wr] = preData;
            next_wr = wr + 5'h01;
          end
          if (preLast) begin
            // The check word is written, then cut off by pulling the pointer back.
            if (next_wr >= CHK_BYTES) begin
              next_wr = next_wr - CHK_BYTES;
              next_copies = 4'h1;
              next_state = P_HELD;
            end else begin
              next_state = P_EMPTY;
            end
          end
        end
      end
      P_HELD: begin
        if (preValid && preFirst && preTime == bufTime && preambleCopies != copiesExpected) begin
          next_copies = preambleCopies + 4'h1;
        end
        if (setupGo && setupTime == bufTime && wr >= CHK_BYTES) begin
          next_stageValid = 1'b1;
          next_stageModulation = mem[0];
          next_stageCoding = mem[1];
        end
        if (discardGo && discardTime == bufTime) begin
          next_state = P_EMPTY;
        end else if (releaseGo && releaseTime == bufTime) begin
          if (wr == '0) begin
            next_state = P_EMPTY;
          end else begin
            next_insValid = 1'b1;
            next_insData = mem[0];
            next_insLast = (wr == 5'h01);
            next_rd = 5'h01;
            next_state = (wr == 5'h01) ? P_EMPTY : P_SEND;
          end
        end
      end
      P_SEND: begin
        next_insValid = 1'b1;
        next_insData = mem[rd];
        next_rd = rd + 5'h01;
        if (next_rd == wr) begin
          next_insLast = 1'b1;
          next_state = P_EMPTY;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= P_EMPTY;
      bufTime <= TIME_RESET;
      wr <= '0;
      rd <= '0;
      hdr <= '0;
      preambleCopies <= 4'h0;
      insValid <= 1'b0;
      insLast <= 1'b0;
      insData <= 8'h00;
      stageValid <= 1'b0;
      stageModulation <= 8'h00;
      stageCoding <= 8'h00;
    end else begin
      state <= next_state;
      bufTime <= next_bufTime;
      wr <= next_wr;
      rd <= next_rd;
      hdr <= next_hdr;
      preambleCopies <= next_copies;
      insValid <= next_insValid;
      insLast <= next_insLast;
      insData <= next_insData;
      stageValid <= next_stageValid;
      stageModulation <= next_stageModulation;
      stageCoding <= next_stageCoding;
    end
  end

  // Storage needs no reset; the pointers guard every read.
  always_ff @(posedge clk) begin
    mem <= next_mem;
  end

  // ==========================================================================
  // Assertions
  a_discard_frees: assert property (@(posedge clk) disable iff (srst)
    state == P_HELD && discardGo && discardTime == bufTime |=> state == P_EMPTY)
    else $error("held preamble kept after its frame was discarded");

endmodule : preamble_parser

//--- verification/demux_model.sv
// Model of the demultiplexer: timing records, preamble packets and the reference tick pin.
// Assumes the bench calls its tasks; released time, config and preamble data lines show inverted data, other record fields the last value.
`timescale 1ns/1ps
module demux_model
  import etpc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Timing records
  output logic tmValid,
  output logic [TIME_W-1:0] tmTime,
  output logic [3:0] tmCopies,
  output logic [3:0] tmPreCopies,
  output logic [15:0] tmOffset,
  output logic [15:0] tmAntDelay,
  output logic [15:0] tmNetDelay,
  output logic [7:0] tmBsConfig,
  output logic [3:0] tmTxIdLevel,
  output logic tmTxIdOn,
  // Time reference
  output logic refTickPin,
  // Preamble bytes
  output logic preValid,
  output logic preFirst,
  output logic preLast,
  output logic [7:0] preData,
  output logic [TIME_W-1:0] preTime
);
  initial begin
    {tmValid, tmTime, tmCopies, tmPreCopies, tmOffset, tmAntDelay} = '0;
    {tmNetDelay, tmBsConfig, tmTxIdLevel, tmTxIdOn, refTickPin} = '0;
    {preValid, preFirst, preLast, preData, preTime} = '0;
  end

  // ==========================================================================
  // Record: offset +5 and antenna delay 3, so launch is two ticks after the time.
  task automatic send_rec(input logic [TIME_W-1:0] t, input logic [7:0] cfg);
    @(posedge clk);
    #2;
    tmValid = 1'b1;
    tmTime = t;
    tmCopies = 4'h3;
    tmPreCopies = 4'h2;
    tmOffset = 16'h0005;
    tmAntDelay = 16'h0003;
    tmNetDelay = {cfg, cfg};
    tmBsConfig = cfg;
    tmTxIdLevel = cfg[3:0];
    tmTxIdOn = cfg[4];
    @(posedge clk);
    #2;
    tmValid = 1'b0;
    tmTime = ~tmTime;
    tmBsConfig = ~tmBsConfig;
  endtask : send_rec

  // ==========================================================================
  // Packet: two length bytes, n payload bytes, two check bytes.
  task automatic send_pre(input logic [TIME_W-1:0] t, input int n, input logic [7:0] pl [8]);
    for (int i = 0; i < n + 4; i++) begin
      @(posedge clk);
      #2;
      preValid = 1'b1;
      preFirst = (i == 0);
      preLast = (i == n + 3);
      preTime = t;
      preData = (i == 1) ? 8'(n + 2) : (i < 2) ? 8'h00 : (i < n + 2) ? pl[i - 2] : 8'h5a;
    end
    @(posedge clk);
    #2;
    {preValid, preFirst, preLast} = 3'h0;
    preData = ~preData;
    preTime = ~preTime;
  endtask : send_pre

  // ==========================================================================
  // Tick: high and low three clocks each, wider than the synchroniser needs.
  task automatic tick;
    @(posedge clk);
    #2;
    refTickPin = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    refTickPin = 1'b0;
    repeat (2) @(posedge clk);
  endtask : tick
endmodule : demux_model

//--- verification/emission_timing_preamble_control_test.sv
// Self-checking bench for the emission timing and preamble control block.
// Assumes the demultiplexer model drives every input except clk and srst.
`timescale 1ns/1ps
module emission_timing_preamble_control_test;
  import etpc_pkg::*;
  logic clk, srst, tmValid, tmTxIdOn, refTickPin, preValid, preFirst, preLast;
  logic freqRef, bootstrapStart, txIdEnable, recordDrop, insValid, insLast, stageValid;
  logic [TIME_W-1:0] tmTime, preTime, timeNow;
  logic [3:0] tmCopies, tmPreCopies, tmTxIdLevel, txIdLevel, preambleCopies;
  logic [15:0] tmOffset, tmAntDelay, tmNetDelay, antennaPathDelayCompensation, dataPathDelay;
  logic [7:0] tmBsConfig, preData, bootstrapConfig, insData, stageModulation, stageCoding;
  logic [80:0] expBoot [$];
  logic [9:0] expIns [$];
  logic [47:0] expStage [$];
  logic expDrop [$];
  logic [7:0] pl [8];
  logic [7:0] seed = 8'h18;
  logic bootPrev = 1'b0;
  logic inStream = 1'b0;
  int fails = 0;
  int totalChecks = 0;
  int pulses = 0;

  demux_model demux_model_inst (.*);
  emission_timing_preamble_control emission_timing_preamble_control_inst (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic cmp(input logic [80:0] got, input logic [80:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Monitor: an empty queue yields x, so any unexpected result is a mismatch.
  always @(negedge clk) begin
    if (!srst) begin
      if (freqRef) pulses++;
      if (bootstrapStart) cmp({timeNow, bootstrapConfig, antennaPathDelayCompensation,
        dataPathDelay, txIdLevel, txIdEnable, preambleCopies},
        expBoot.size() ? expBoot.pop_front() : 'x, "bootstrap");
      if (stageValid) cmp({timeNow, stageModulation, stageCoding},
        expStage.size() ? expStage.pop_front() : 'x, "stage");
      if (insValid) begin
        cmp({!inStream && bootPrev, insLast, insData},
          expIns.size() ? expIns.pop_front() : 'x, "preamble");
        inStream = !insLast;
      end
      if (recordDrop) cmp(1'b1, expDrop.size() ? expDrop.pop_front() : 'x, "drop");
      bootPrev = bootstrapStart;
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    srst = 1'b1;
    repeat (8) @(posedge clk);
    #2;
    srst = 1'b0;
    @(negedge clk);
    cmp({timeNow, bootstrapStart, insValid, stageValid}, '0, "reset");
    $display("test reset done");
    // Three copies, the middle one corrupt: the vote must keep the majority.
    expBoot.push_back({32'h0000_002a, 8'h35, 16'h0003, 16'h3535, 4'h5, 1'b1, 4'h2});
    for (int i = 0; i < 3; i++) begin
      demux_model_inst.send_rec(32'h0000_0028, (i == 1) ? 8'hca : 8'h35);
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      pl[i] = seed;
      expIns.push_back({i == 0, i == 5, seed});
    end
    expStage.push_back({32'h0000_001a, pl[0], pl[1]});
    repeat (2) demux_model_inst.send_pre(32'h0000_0028, 6, pl);
    repeat (44) demux_model_inst.tick();
    cmp(timeNow, 32'h0000_002c, "time");
    cmp(pulses, 44, "frequency");
    $display("test frame done");
    // A stale record and its held preamble are freed at the next tick, leaving four slots.
    demux_model_inst.send_pre(32'h0000_000a, 2, pl);
    demux_model_inst.send_rec(32'h0000_000a, 8'h11);
    demux_model_inst.tick();
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      if (i == 4) expDrop.push_back(1'b1);
      demux_model_inst.send_rec(32'h0010_0000 + i, seed);
    end
    repeat (4) @(posedge clk);
    cmp(expBoot.size() + expIns.size() + expStage.size() + expDrop.size(), 0, "left");
    $display("test store done");
    report_and_stop();
  end

  // Expected run is near 330 clocks; the watchdog allows about six times that.
  initial begin
    #50000;
    fails++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : emission_timing_preamble_control_test
